// >>> logic/odc_cfg.svh
// constants for the octal converter serial control block
// Operation
// - frame is 16 bits: command, 10-bit code MSB first, two zeros; sampled on falling sclk
// - word acted on only after 16 bits and chip select high
// - decode commands: nop, reset, load input 1-8, write-through groups, load all
// - command 1110 copies masked input registers into dac registers
// - a new frame starts when chip select falls
// - chip select rising before 16 clocks discards the word
// - serial clock may idle high or low between frames
// - input registers and dac registers are kept separate
// - command 1111 mode 11 powers up masked channels
// - command 1111 mode 01 puts masked channels in high-impedance shutdown
// - command 1111 mode 10 shuts masked channels down with low-value termination
// - command 1111 mode 00 shuts masked channels down with high-value termination
// - chain output is serial input delayed 16 clocks, changing after falling edges
// - clear resets registers and shuts all channels with high-value termination
// - clear acts at any moment, independent of serial clock
// - clear during a word aborts it; host resends
// - power-on clear zeros dac registers and powers channels down
// - after power-up all registers are zero and chain output low
// - chained frames: each device executes its own 16 bits at chip select rise
`ifndef ODC_CFG_SVH
`define ODC_CFG_SVH
`define ODC_WORD_BITS 16
`define ODC_CODE_BITS 10
`define ODC_CHANNELS 8
`define ODC_CMD_NOP 4'h0
`define ODC_CMD_RESET 4'h1
`define ODC_CMD_LOAD_FIRST 4'h2
`define ODC_CMD_LOAD_LAST 4'h9
`define ODC_CMD_THRU_LO 4'ha
`define ODC_CMD_THRU_HI 4'hb
`define ODC_CMD_THRU_ALL 4'hc
`define ODC_CMD_LOAD_ALL 4'hd
`define ODC_CMD_UPDATE 4'he
`define ODC_CMD_POWER 4'hf
`define ODC_CMD_POS 12
`define ODC_CODE_POS 2
`define ODC_MASK_POS 4
`define ODC_MODE_POS 2
`endif

// >>> logic/odc_pkg.sv
// types for the octal converter serial control block
package odc_pkg;
    typedef enum logic [1:0] {
        ODC_SHDN_HIGH_R = 2'b00,
        ODC_SHDN_HIZ = 2'b01,
        ODC_SHDN_LOW_R = 2'b10,
        ODC_ACTIVE = 2'b11
    } odc_mode_t;
    typedef struct packed {
        logic cs_n;
        logic sclk;
        logic din;
    } odc_link_t;
    typedef struct packed {
        logic [3:0] cmd;
        logic [9:0] code;
        logic [1:0] pad;
    } odc_word_t;
endpackage

// >>> logic/odc_link_sync.sv
// two-flop synchroniser for the serial link pins
`timescale 1ns/10ps
module odc_link_sync
    import odc_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input odc_pkg::odc_link_t link_in,
    output odc_pkg::odc_link_t link_out
);
    odc_link_t stage1;
    odc_link_t stage2;
    assign link_out = stage2;
    // idle cs_n high so no false frame at reset
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            stage1 <= '{cs_n: 1'b1, sclk: 1'b0, din: 1'b0};
            stage2 <= '{cs_n: 1'b1, sclk: 1'b0, din: 1'b0};
        end
        else
        begin
            stage1 <= link_in;
            stage2 <= stage1;
        end
    end
endmodule

// >>> logic/odc_top.sv
// serial command decoder, double-buffered registers and shutdown control
`timescale 1ns/10ps
`include "odc_cfg.svh"
module odc_top
    import odc_pkg::*;
#(
    parameter int CHANNELS = `ODC_CHANNELS,
    parameter int CODE_BITS = `ODC_CODE_BITS
)
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic async_clear_n,
    input odc_pkg::odc_link_t link,
    output logic chain_out,
    output logic [CHANNELS*CODE_BITS-1:0] dac_code,
    output logic [CHANNELS*CODE_BITS-1:0] input_code,
    output odc_pkg::odc_mode_t [CHANNELS-1:0] channel_mode,
    output logic word_done
);
    import odc_pkg::*;

    odc_link_t link_s;
    logic clr_s1;
    logic clr_s2;
    logic sclk_d;
    logic cs_d;
    logic [`ODC_WORD_BITS-1:0] shift;
    logic [`ODC_WORD_BITS-1:0] chain_pipe;
    logic [4:0] bit_cnt;
    logic [CODE_BITS-1:0] in_reg [CHANNELS];
    logic [CODE_BITS-1:0] dac_reg [CHANNELS];
    odc_mode_t mode_reg [CHANNELS];

    odc_link_sync u_sync (
        .clk(clk),
        .rst(sys_rst),
        .link_in(link),
        .link_out(link_s)
    );

    // clear pin crosses through two flops; it still wins at any time
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            clr_s1 <= 1'b0;
            clr_s2 <= 1'b0;
        end
        else
        begin
            clr_s1 <= ~async_clear_n;
            clr_s2 <= clr_s1;
        end
    end

    // edge detection on the synchronised pins
    wire clear_now = clr_s2;
    wire sclk_fall = sclk_d & ~link_s.sclk;
    wire cs_fall = cs_d & ~link_s.cs_n;
    wire cs_rise = ~cs_d & link_s.cs_n;
    wire in_frame = ~link_s.cs_n;
    wire shift_en = in_frame & sclk_fall;
    wire [4:0] next_bit_cnt = (bit_cnt == 5'h10) ? bit_cnt : bit_cnt + 5'h01;
    wire word_full = (bit_cnt == 5'h10);
    wire execute = cs_rise & word_full & ~clear_now;

    // captured word fields
    odc_word_t word;
    assign word = shift;
    wire [3:0] cmd = word.cmd;
    wire [CODE_BITS-1:0] code = word.code;
    wire [CHANNELS-1:0] mask = shift[`ODC_MASK_POS +: 8];
    wire [1:0] mode_sel = shift[`ODC_MODE_POS +: 2];
    wire is_reset = execute & (cmd == `ODC_CMD_RESET);
    wire is_update = execute & (cmd == `ODC_CMD_UPDATE);
    wire is_power = execute & (cmd == `ODC_CMD_POWER);
    wire is_load_all = execute & ((cmd == `ODC_CMD_LOAD_ALL) | (cmd == `ODC_CMD_THRU_ALL));
    wire is_thru_lo = execute & (cmd == `ODC_CMD_THRU_LO);
    wire is_thru_hi = execute & (cmd == `ODC_CMD_THRU_HI);
    wire is_thru_all = execute & (cmd == `ODC_CMD_THRU_ALL);
    wire [3:0] load_idx = cmd - `ODC_CMD_LOAD_FIRST;
    wire is_load_one = execute & (cmd >= `ODC_CMD_LOAD_FIRST) & (cmd <= `ODC_CMD_LOAD_LAST);
    wire wipe = clear_now | is_reset;

    // frame tracking: count resets at cs fall, clear aborts a word
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            sclk_d <= 1'b0;
            cs_d <= 1'b1;
            bit_cnt <= 5'h00;
            shift <= 16'h0000;
            word_done <= 1'b0;
        end
        else
        begin
            sclk_d <= link_s.sclk;
            cs_d <= link_s.cs_n;
            word_done <= execute;
            if (clear_now | cs_fall | ~in_frame)
                bit_cnt <= 5'h00;
            else if (shift_en)
                bit_cnt <= next_bit_cnt;
            if (clear_now)
                shift <= 16'h0000;
            else if (shift_en)
                shift <= {shift[`ODC_WORD_BITS-2:0], link_s.din};
        end
    end

    // chain delay line follows the data pin by 16 falling edges
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            chain_pipe <= 16'h0000;
            chain_out <= 1'b0;
        end
        else if (clear_now)
        begin
            chain_pipe <= 16'h0000;
            chain_out <= 1'b0;
        end
        else if (shift_en)
        begin
            chain_pipe <= {chain_pipe[`ODC_WORD_BITS-2:0], link_s.din};
            chain_out <= chain_pipe[`ODC_WORD_BITS-1];
        end
    end

    // per-channel double-buffered registers and power state
    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch++)
        begin : g_ch
            wire in_grp_lo = (ch < 4);
            wire load_in = is_load_all | (is_load_one & (load_idx == 4'(ch)))
                | (is_thru_lo & in_grp_lo) | (is_thru_hi & ~in_grp_lo);
            wire thru = is_thru_all | (is_thru_lo & in_grp_lo) | (is_thru_hi & ~in_grp_lo);
            wire copy = is_update & mask[ch];
            wire set_mode = is_power & mask[ch];
            always_ff @(posedge clk)
            begin
                if (sys_rst | wipe)
                begin
                    in_reg[ch] <= '0;
                    dac_reg[ch] <= '0;
                    mode_reg[ch] <= ODC_SHDN_HIGH_R;
                end
                else
                begin
                    if (load_in)
                        in_reg[ch] <= code;
                    if (thru)
                        dac_reg[ch] <= code;
                    else if (copy)
                        dac_reg[ch] <= in_reg[ch];
                    if (set_mode)
                        mode_reg[ch] <= odc_mode_t'(mode_sel);
                end
            end
            // outputs registered one more stage so they come from flops
            always_ff @(posedge clk)
            begin
                if (sys_rst)
                begin
                    dac_code[ch*CODE_BITS +: CODE_BITS] <= '0;
                    input_code[ch*CODE_BITS +: CODE_BITS] <= '0;
                    channel_mode[ch] <= ODC_SHDN_HIGH_R;
                end
                else
                begin
                    dac_code[ch*CODE_BITS +: CODE_BITS] <= dac_reg[ch];
                    input_code[ch*CODE_BITS +: CODE_BITS] <= in_reg[ch];
                    channel_mode[ch] <= mode_reg[ch];
                end
            end
        end
    endgenerate

    // checks on the internal behaviour
    a_short_discard: assert property (@(posedge clk) disable iff (sys_rst)
        (cs_rise & ~word_full) |-> ~execute) else $error("short frame executed");
    a_exec_at_rise: assert property (@(posedge clk) disable iff (sys_rst)
        execute |-> cs_rise & (bit_cnt == 5'h10)) else $error("execute off cs rise");
    a_done_follows: assert property (@(posedge clk) disable iff (sys_rst)
        execute |=> word_done) else $error("word_done missing");
    a_clear_wipes: assert property (@(posedge clk) disable iff (sys_rst)
        clear_now |=> (mode_reg[0] == ODC_SHDN_HIGH_R) && (dac_reg[0] == '0))
        else $error("clear did not wipe");
    a_clear_abort: assert property (@(posedge clk) disable iff (sys_rst)
        clear_now |=> (bit_cnt == 5'h00) && (shift == 16'h0000))
        else $error("clear did not abort word");
    a_cs_fall_start: assert property (@(posedge clk) disable iff (sys_rst)
        cs_fall |=> (bit_cnt == 5'h00)) else $error("frame did not restart");
    a_update_copy: assert property (@(posedge clk) disable iff (sys_rst)
        (is_update & mask[0]) |=> (dac_reg[0] == $past(in_reg[0])))
        else $error("update did not copy");
    a_power_mode: assert property (@(posedge clk) disable iff (sys_rst)
        (is_power & mask[1] & ~clear_now) |=> (mode_reg[1] == odc_mode_t'($past(mode_sel))))
        else $error("mode not applied");
    a_unmasked_keep: assert property (@(posedge clk) disable iff (sys_rst)
        (is_power & ~mask[2]) |=> $stable(mode_reg[2])) else $error("unmasked changed");
    a_chain_delay: assert property (@(posedge clk) disable iff (sys_rst)
        (shift_en & ~clear_now) |=> (chain_out == $past(chain_pipe[15])))
        else $error("chain output wrong");
    a_load_sep: assert property (@(posedge clk) disable iff (sys_rst)
        (is_load_one & (load_idx == 4'h0) & ~clear_now) |=> $stable(dac_reg[0]))
        else $error("load touched dac register");

    c_exec: cover property (@(posedge clk) execute);
    c_short: cover property (@(posedge clk) cs_rise & ~word_full & (bit_cnt != 5'h00));
    c_power: cover property (@(posedge clk) is_power);
    c_clear_mid: cover property (@(posedge clk) clear_now & in_frame & (bit_cnt != 5'h00));
endmodule

// >>> verif/odc_host.sv
// serial host model driving the converter link
`timescale 1ns/10ps
module odc_host
(
    input wire logic clk,
    input wire logic chain_in,
    output odc_pkg::odc_link_t link
);
    import odc_pkg::*;
    logic idle = 1'b0;
    logic [31:0] chain_seen = '0;
    initial link = '{cs_n: 1'b1, sclk: 1'b0, din: 1'b0};
    // whole clocks, so pin changes land away from the sampling edge
    task automatic ticks(input int n);
        repeat (n) @(negedge clk);
    endtask
    // one frame of n bits, msb first; sclk 4 clk high then 4 clk low
    task automatic frame(input logic [31:0] bits, input int n);
        link.sclk = idle;
        ticks(1);
        link.cs_n = 1'b0;
        ticks(4);
        for (int i = n - 1; i >= 0; i--)
        begin
            link.din = bits[i];
            link.sclk = 1'b1;
            ticks(4);
            link.sclk = 1'b0;
            ticks(4);
            // chain output has settled about 4 clk after the fall
            chain_seen = {chain_seen[30:0], chain_in};
        end
        link.cs_n = 1'b1;
        link.sclk = idle;
        link.din = ~link.din; // released line must not keep a stale value
        ticks(8);
    endtask
endmodule

// >>> verif/odc_top_bench.sv
// self-checking bench for the octal converter control block
`timescale 1ns/10ps
module odc_top_bench;
    import odc_pkg::*;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic async_clear_n = 1'b1;
    odc_link_t link;
    logic chain_out;
    logic word_done;
    logic [79:0] dac_code;
    logic [79:0] input_code;
    odc_mode_t [7:0] channel_mode;
    logic [9:0] m_in [8] = '{default: '0};
    logic [9:0] m_dac [8] = '{default: '0};
    logic [1:0] m_mode [8] = '{default: '0};
    int num_errors = 0;
    int total_checks = 0;
    int dones = 0;
    int m_dones = 0;
    int cycles = 0;
    // words sent in turn; expected registers come from the model below
    logic [15:0] rows [20] = '{16'h2ffc, 16'h3004, 16'h4808, 16'h5a00, 16'h6554, 16'h7aa8,
        16'h8ffc, 16'h9004, 16'he0f0, 16'hfffc, 16'hf014, 16'hf228, 16'hf400, 16'h1000,
        16'ha400, 16'hb804, 16'hd7fc, 16'he3c0, 16'hc154, 16'hf150};
    always #10 clk = ~clk;
    odc_top dut (.clk(clk), .sys_rst(sys_rst), .async_clear_n(async_clear_n), .link(link),
        .chain_out(chain_out), .dac_code(dac_code), .input_code(input_code),
        .channel_mode(channel_mode), .word_done(word_done));
    odc_host host (.clk(clk), .chain_in(chain_out), .link(link));
    // completion pulses and the cycle ceiling against a stuck run
    always @(posedge clk)
    begin
        cycles++;
        if (word_done === 1'b1)
            dones++;
        if (cycles == 20000)
        begin
            num_errors++;
            final_report();
        end
    end
    task automatic check(input logic [79:0] seen, input logic [79:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // reference model of one executed word
    function automatic void apply(input logic [15:0] w);
        logic [3:0] c;
        logic wr_in;
        logic thru;
        c = w[15:12];
        m_dones++;
        for (int i = 0; i < 8; i++)
        begin
            thru = (c == 4'ha && i < 4) || (c == 4'hb && i > 3) || c == 4'hc;
            wr_in = thru || c == 4'hd || c == 4'(i + 2);
            m_in[i] = (c == 4'h1) ? '0 : wr_in ? w[11:2] : m_in[i];
            m_dac[i] = (c == 4'h1) ? '0 : thru ? w[11:2] : (c == 4'he && w[4 + i]) ? m_in[i] : m_dac[i];
            m_mode[i] = (c == 4'h1) ? 2'h0 : (c == 4'hf && w[4 + i]) ? w[3:2] : m_mode[i];
        end
    endfunction
    task automatic compare_all();
        logic [79:0] ei;
        logic [79:0] ed;
        logic [15:0] em;
        for (int i = 0; i < 8; i++)
        begin
            ei[i*10+:10] = m_in[i];
            ed[i*10+:10] = m_dac[i];
            em[i*2+:2] = m_mode[i];
        end
        check(input_code, ei);
        check(dac_code, ed);
        check(80'(channel_mode), 80'(em));
        check(80'(dones), 80'(m_dones));
    endtask
    task automatic final_report();
        $display("errors %0d checks %0d", num_errors, total_checks);
        if (num_errors == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (16) @(negedge clk);
        sys_rst = 1'b0;
        repeat (3) @(negedge clk);
        compare_all();
        check(80'(chain_out), 80'h0);
        // every command except nop and every mode, sclk idling low and high in turn
        foreach (rows[k])
        begin
            host.idle = k[0];
            host.frame(32'(rows[k]), 16);
            apply(rows[k]);
            compare_all();
        end
        // short frame must change nothing
        host.frame(32'h2000, 15);
        compare_all();
        // two words in one frame: no-op first for the next device down
        host.frame({16'h0ffc, 16'h3ffc}, 32);
        apply(16'h3ffc);
        compare_all();
        check(80'(host.chain_seen[15:0]), 80'h0ffc);
        // clear pulled in mid-word aborts it and wipes the state
        fork
            host.frame(32'h4ffc, 16);
            begin
                repeat (40) @(negedge clk);
                async_clear_n = 1'b0;
                repeat (10) @(negedge clk);
                async_clear_n = 1'b1;
            end
        join
        apply(16'h1000);
        m_dones--;
        compare_all();
        host.frame(32'h4ffc, 16);
        apply(16'h4ffc);
        compare_all();
        final_report();
    end
endmodule
